// file: src/swb_pkg.sv
// shared constants, types and timing counts of the single wire byte engine
// assumes a 25 mhz system clock and a front end that decodes the host bus

package swb_pkg;

   // ********************************************************************
   // clock and timing
   // ********************************************************************
   localparam int CLK_PERIOD_PS = 40000;
   localparam int START_MAX_PS  = 262500;   // latest start of line activity
   localparam int START_MAX_CYC = START_MAX_PS / CLK_PERIOD_PS; // rounds down

   // slot figures in ns; plain defaults, tuned per system
   localparam int STD_SLOT_NS   = 70000;
   localparam int STD_LOW1_NS   = 6000;
   localparam int STD_LOW0_NS   = 60000;
   localparam int STD_SAMPLE_NS = 15000;
   localparam int OD_SLOT_NS    = 10000;
   localparam int OD_LOW1_NS    = 1000;
   localparam int OD_LOW0_NS    = 8000;
   localparam int OD_SAMPLE_NS  = 2000;

   // least times round up to whole cycles
   localparam int CLK_PERIOD_NS  = CLK_PERIOD_PS / 1000;
   localparam int STD_SLOT_CYC   =
      (STD_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STD_LOW1_CYC   =
      (STD_LOW1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STD_LOW0_CYC   =
      (STD_LOW0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STD_SAMPLE_CYC =
      (STD_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OD_SLOT_CYC    =
      (OD_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OD_LOW1_CYC    =
      (OD_LOW1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OD_LOW0_CYC    =
      (OD_LOW0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OD_SAMPLE_CYC  =
      (OD_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int CNT_W = 11;               // holds the longest slot count

   // ********************************************************************
   // commands and fields
   // ********************************************************************
   localparam logic [7:0] CMD_WRITE_BYTE = 8'ha5;
   localparam logic [7:0] CMD_READ_BYTE  = 8'h96;
   localparam logic [7:0] CMD_SINGLE_BIT = 8'h87;
   localparam int         BIT_VALUE_POS  = 7;
   localparam logic [3:0] LAST_BIT_BYTE  = 4'h7;
   localparam logic [3:0] LAST_BIT_ONE   = 4'h0;
   localparam logic [7:0] READ_FILL      = 8'hff;  // read slots send ones
   localparam logic [7:0] BYTE_RST       = 8'h00;

   // ********************************************************************
   // types
   // ********************************************************************
   typedef enum logic [1:0] {
      SWB_IDLE      = 2'b00,
      SWB_WAIT_DATA = 2'b01,
      SWB_RUN       = 2'b10
   } swb_state_t;

   typedef enum logic [1:0] {
      SWB_KIND_WRITE = 2'b00,
      SWB_KIND_READ  = 2'b01,
      SWB_KIND_BIT   = 2'b10
   } swb_kind_t;

   typedef struct packed {
      logic od;      // overdrive_speed_select
      logic strong_pullup_enable;     // strong_pullup_enable
      logic active_pullup_enable;     // active_pullup_enable
   } swb_cfg_t;

   typedef struct packed {
      swb_state_t state;
      swb_kind_t  kind;
      swb_cfg_t   cfg;
      logic [7:0] shreg;
      logic [7:0] rxbyte;
      logic [3:0] bit_cnt;
      logic [3:0] last_bit;
      logic       busy;
      logic       ptr_pulse;
      logic       slot_start;
      logic       slot_bit;
      logic [7:0] read_data;
      logic       read_done;
   } swb_ctl_t;

   typedef struct packed {
      logic             active;
      logic             od;
      logic             bit_value;
      logic [CNT_W-1:0] cnt;
      logic             drive_low;
      logic             sample_valid;
      logic             sample_bit;
      logic             done;
   } swb_slot_t;

endpackage

// file: src/swb_slot_gen.sv
// one time slot on the single wire line: drive low, release, sample
// assumes line_in is already synchronous to sys_clk_in

`timescale 1ns/1ps

module swb_slot_gen
   import swb_pkg::*;
#(
   parameter logic [CNT_W-1:0] STD_SLOT   = CNT_W'(STD_SLOT_CYC),
   parameter logic [CNT_W-1:0] STD_LOW1   = CNT_W'(STD_LOW1_CYC),
   parameter logic [CNT_W-1:0] STD_LOW0   = CNT_W'(STD_LOW0_CYC),
   parameter logic [CNT_W-1:0] STD_SAMPLE = CNT_W'(STD_SAMPLE_CYC),
   parameter logic [CNT_W-1:0] OD_SLOT    = CNT_W'(OD_SLOT_CYC),
   parameter logic [CNT_W-1:0] OD_LOW1    = CNT_W'(OD_LOW1_CYC),
   parameter logic [CNT_W-1:0] OD_LOW0    = CNT_W'(OD_LOW0_CYC),
   parameter logic [CNT_W-1:0] OD_SAMPLE  = CNT_W'(OD_SAMPLE_CYC)
) (
   input  wire logic sys_clk_in,
   input  wire logic sys_rst_in,
   input  wire logic start_in,
   input  wire logic bit_in,
   input  wire logic od_in,
   input  wire logic line_in,
   output logic      drive_low_out,
   output logic      sample_valid_out,
   output logic      sample_bit_out,
   output logic      done_out
);

   swb_slot_t st;
   swb_slot_t next_st;
   logic [CNT_W-1:0] cnt_nx;
   logic [CNT_W-1:0] low_len;
   logic [CNT_W-1:0] samp_at;
   logic [CNT_W-1:0] end_at;

   // ********************************************************************
   // slot sequencing
   // ********************************************************************
   // done rises two counts before the pitch: the engine registers the
   // restart one cycle later and the generator one more, so the pitch is
   // exact and eight slots fit the busy bound
   always_comb begin
      next_st              = st;
      next_st.sample_valid = 1'b0;
      next_st.done         = 1'b0;
      cnt_nx   = st.cnt + 1'b1;
      low_len  = st.od ? (st.bit_value ? OD_LOW1 : OD_LOW0)
                       : (st.bit_value ? STD_LOW1 : STD_LOW0);
      samp_at  = st.od ? OD_SAMPLE : STD_SAMPLE;
      end_at   = (st.od ? OD_SLOT : STD_SLOT) - 2'd2;     // R5 R12
      if (!st.active) begin
         if (start_in) begin
            next_st.active    = 1'b1;
            next_st.od        = od_in;
            next_st.bit_value = bit_in;
            next_st.cnt       = '0;
            next_st.drive_low = 1'b1;
         end
      end else begin
         next_st.cnt = cnt_nx;
         if (cnt_nx == low_len) begin
            next_st.drive_low = 1'b0;
         end
         if (cnt_nx == samp_at) begin
            next_st.sample_valid = 1'b1;
            next_st.sample_bit   = line_in;
         end
         if (cnt_nx == end_at) begin
            next_st.active    = 1'b0;
            next_st.drive_low = 1'b0;
            next_st.done      = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign drive_low_out    = st.drive_low;
   assign sample_valid_out = st.sample_valid;
   assign sample_bit_out   = st.sample_bit;
   assign done_out         = st.done;

endmodule // swb_slot_gen

// file: src/swb_byte_engine.sv
// byte and bit command engine of the single wire master
// assumes a host bus front end that presents each received command code
// and parameter byte as a one-cycle strobe and asks for the ack decision
//
// Notes on behaviour
// (R1) single-bit parameter carries the bit in bit 7; other bits ignored
// (R2) write-byte code a5 plus data byte sends eight write slots
// (R3) host issues byte commands only after previous line activity ends
// (R4) busy at write-byte code: no ack for code or data, command dropped
// (R5) write-byte finishes within eight slot periods plus 262.5 ns
// (R6) write-byte line activity starts within 262.5 ns of last data bit
// (R7) bytes go out on the line least significant bit first
// (R8) accepted byte command points the read pointer at status
// (R9) read-byte code 96 runs eight read slots, stores byte in read data
// (R10) read-byte line behaviour equals eight write-one/read slots
// (R11) busy at read-byte code: code not acked, command dropped
// (R12) read-byte finishes within eight slot periods plus 262.5 ns
// (R13) read-byte line activity starts within 262.5 ns of code ack
// (R14) host sets read pointer to read data, then reads the byte
// (R15) write honours speed, strong and active pullup; read not strong
// (R16) line busy flag high across the slots, cleared at last slot end

`timescale 1ns/1ps

module swb_byte_engine
   import swb_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       cmd_valid_in,
   input  wire logic [7:0] cmd_code_in,
   input  wire logic       data_valid_in,
   input  wire logic [7:0] data_in,
   input  wire logic       overdrive_speed_select_in,
   input  wire logic       strong_pullup_enable_in,
   input  wire logic       active_pullup_enable_in,
   input  wire logic       line_in,
   output logic            cmd_ack_out,
   output logic            data_ack_out,
   output logic            read_ptr_status_out,
   output logic            line_busy_flag_out,
   output logic [7:0]      read_data_out,
   output logic            read_data_valid_out,
   output logic            line_out,
   output logic            line_oe_out,
   output logic            strong_pullup_out,
   output logic            active_pullup_out
);

   // ********************************************************************
   // decoding
   // ********************************************************************
   function automatic logic cmd_known(input logic [7:0] code);
      cmd_known = (code == CMD_WRITE_BYTE) || (code == CMD_READ_BYTE) ||
                  (code == CMD_SINGLE_BIT);
   endfunction

   function automatic swb_kind_t cmd_kind(input logic [7:0] code);
      if (code == CMD_READ_BYTE) begin
         cmd_kind = SWB_KIND_READ;
      end else if (code == CMD_SINGLE_BIT) begin
         cmd_kind = SWB_KIND_BIT;
      end else begin
         cmd_kind = SWB_KIND_WRITE;
      end
   endfunction

   swb_ctl_t  st;
   swb_ctl_t  next_st;
   swb_kind_t new_kind;
   logic      cmd_ack;
   logic      data_ack;
   logic      slot_drive_low;
   logic      slot_sample_valid;
   logic      slot_sample_bit;
   logic      slot_done;

   // ********************************************************************
   // acknowledge decisions
   // ********************************************************************
   // combinational so the front end can answer in the ack bit itself
   assign new_kind = cmd_kind(cmd_code_in);
   assign cmd_ack  = cmd_valid_in && !st.busy &&
                     cmd_known(cmd_code_in);                      // R4 R11
   assign data_ack = data_valid_in && (st.state == SWB_WAIT_DATA);       // R4

   // ********************************************************************
   // command sequencing
   // ********************************************************************
   // a new code while waiting for data abandons the earlier command; the
   // front end only ever sends one parameter byte per code
   always_comb begin
      next_st            = st;
      next_st.ptr_pulse  = 1'b0;
      next_st.slot_start = 1'b0;
      next_st.read_done  = 1'b0;
      unique case (st.state)
         SWB_IDLE, SWB_WAIT_DATA: begin
            if (cmd_ack) begin
               next_st.ptr_pulse = 1'b1;                              // R8
               next_st.kind      = new_kind;
               next_st.cfg.od    = overdrive_speed_select_in;         // R15
               next_st.cfg.active_pullup_enable   = active_pullup_enable_in;           // R15
               next_st.cfg.strong_pullup_enable   = strong_pullup_enable_in &&
                                   (new_kind != SWB_KIND_READ);       // R15
               next_st.bit_cnt   = '0;
               if (new_kind == SWB_KIND_READ) begin
                  // read slots start right after the code ack
                  next_st.state      = SWB_RUN;                       // R9
                  next_st.busy       = 1'b1;                          // R16
                  next_st.shreg      = READ_FILL;                     // R10
                  next_st.slot_bit   = 1'b1;                          // R10
                  next_st.slot_start = 1'b1;                          // R13
                  next_st.last_bit   = LAST_BIT_BYTE;
                  next_st.rxbyte     = BYTE_RST;
               end else begin
                  next_st.state = SWB_WAIT_DATA;
               end
            end else if (data_ack) begin
               // whole byte is in hand, so the first slot can go at once
               next_st.state      = SWB_RUN;                          // R2
               next_st.busy       = 1'b1;                             // R16
               next_st.slot_start = 1'b1;                             // R6
               next_st.shreg      = data_in;
               if (st.kind == SWB_KIND_BIT) begin
                  next_st.slot_bit = data_in[BIT_VALUE_POS];          // R1
                  next_st.last_bit = LAST_BIT_ONE;
               end else begin
                  next_st.slot_bit = data_in[0];                      // R7
                  next_st.last_bit = LAST_BIT_BYTE;
               end
            end
         end
         SWB_RUN: begin
            if (slot_sample_valid) begin
               // line bits arrive lsb first, so shift in from the top
               next_st.rxbyte = {slot_sample_bit, st.rxbyte[7:1]};    // R9
            end
            if (slot_done) begin
               if (st.bit_cnt == st.last_bit) begin
                  next_st.state = SWB_IDLE;
                  next_st.busy  = 1'b0;                       // R16 R5 R12
                  if (st.kind == SWB_KIND_READ) begin
                     next_st.read_data = st.rxbyte;                   // R9
                     next_st.read_done = 1'b1;
                  end
               end else begin
                  next_st.bit_cnt    = st.bit_cnt + 1'b1;
                  next_st.shreg      = {1'b1, st.shreg[7:1]};         // R7
                  next_st.slot_bit   = st.shreg[1];                   // R7
                  next_st.slot_start = 1'b1;
               end
            end
         end
         default: begin
            next_st = '0;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ********************************************************************
   // slot generator
   // ********************************************************************
   swb_slot_gen u_slot (
      .sys_clk_in       (sys_clk_in),
      .sys_rst_in       (sys_rst_in),
      .start_in         (st.slot_start),
      .bit_in           (st.slot_bit),
      .od_in            (st.cfg.od),
      .line_in          (line_in),
      .drive_low_out    (slot_drive_low),
      .sample_valid_out (slot_sample_valid),
      .sample_bit_out   (slot_sample_bit),
      .done_out         (slot_done)
   );

   // ********************************************************************
   // outputs
   // ********************************************************************
   // open-drain line: only ever drives low; pullups help only while the
   // line is released inside a command
   assign cmd_ack_out         = cmd_ack;
   assign data_ack_out        = data_ack;
   assign read_ptr_status_out = st.ptr_pulse;
   assign line_busy_flag_out  = st.busy;
   assign read_data_out       = st.read_data;
   assign read_data_valid_out = st.read_done;
   assign line_out            = 1'b0;
   assign line_oe_out         = slot_drive_low;
   assign strong_pullup_out   = st.cfg.strong_pullup_enable && (st.state == SWB_RUN) &&
                                !slot_drive_low;                       // R15
   assign active_pullup_out   = st.cfg.active_pullup_enable && (st.state == SWB_RUN) &&
                                !slot_drive_low;                       // R15

   // ********************************************************************
   // checks
   // ********************************************************************
   localparam int AST_START_MAX = START_MAX_CYC;
   localparam int AST_BUSY_MAX  = 8 * STD_SLOT_CYC + START_MAX_CYC;

   logic [15:0] busy_len;

   // helper: length of the current busy stretch
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         busy_len <= '0;
      end else begin
         busy_len <= st.busy ? busy_len + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   AST_REFUSE_BUSY: assert property ( // R4
      cmd_valid_in && st.busy |-> !cmd_ack_out ##1 !read_ptr_status_out)
      else $error("command acked while line busy");
   AST_READ_REFUSE: assert property ( // R11
      cmd_valid_in && st.busy && cmd_code_in == CMD_READ_BYTE
      |=> !read_ptr_status_out && $stable(st.kind) && $stable(st.cfg))
      else $error("read command not dropped while busy");
   AST_DATA_NO_ACK: assert property ( // R4
      data_valid_in && st.state != SWB_WAIT_DATA |-> !data_ack_out)
      else $error("data byte acked without pending command");
   AST_WRITE_START: assert property ( // R6
      data_ack_out && st.kind == SWB_KIND_WRITE
      |-> ##[1:AST_START_MAX] line_oe_out)
      else $error("write line activity started late");
   AST_READ_START: assert property ( // R13
      cmd_ack_out && cmd_code_in == CMD_READ_BYTE
      |-> ##[1:AST_START_MAX] line_oe_out)
      else $error("read line activity started late");
   AST_PTR_STATUS: assert property ( // R8
      cmd_ack_out |=> read_ptr_status_out ##1
      read_ptr_status_out == $past(cmd_ack_out))
      else $error("read pointer not moved to status");
   AST_LSB_FIRST: assert property ( // R7
      data_ack_out && st.kind == SWB_KIND_WRITE
      |=> st.slot_start && st.slot_bit == $past(data_in[0]))
      else $error("first slot is not the lsb");
   AST_BIT_VALUE: assert property ( // R1
      data_ack_out && st.kind == SWB_KIND_BIT
      |=> st.slot_bit == $past(data_in[7]) && st.last_bit == LAST_BIT_ONE)
      else $error("single bit value not taken from bit 7");
   AST_READ_ONES: assert property ( // R10
      st.slot_start && st.kind == SWB_KIND_READ |-> st.slot_bit)
      else $error("read slot is not a write-one slot");
   AST_BUSY_SET: assert property ( // R16
      (data_ack_out || (cmd_ack_out && cmd_code_in == CMD_READ_BYTE))
      |=> line_busy_flag_out)
      else $error("busy not set on command start");
   AST_BUSY_LEN: assert property ( // R5 R12
      busy_len <= 16'(AST_BUSY_MAX))
      else $error("byte command ran too long");
   AST_READ_STORE: assert property ( // R9
      read_data_valid_out |-> !line_busy_flag_out &&
      read_data_out == $past(st.rxbyte))
      else $error("read byte not stored at end");
   AST_NO_SPU_READ: assert property ( // R15
      st.kind == SWB_KIND_READ && st.state == SWB_RUN |-> !strong_pullup_out)
      else $error("strong pullup during read byte");

   COV_WRITE: cover property (
      data_ack_out && st.kind == SWB_KIND_WRITE ##1 line_busy_flag_out);
   COV_READ: cover property (read_data_valid_out);
   COV_REFUSED: cover property (cmd_valid_in && st.busy);
   COV_BIT: cover property (data_ack_out && st.kind == SWB_KIND_BIT);

endmodule // swb_byte_engine

// file: bench/swb_slave_model.sv
// behavioural far side of the single wire line: one slave device
// assumes the master pulls low while oe_in is high and a pull-up holds
// the released line high

`timescale 1ns/1ps

// ********************************************************************
// slave model
// ********************************************************************
module swb_slave_model
   import swb_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       oe_in,
   input  wire logic       od_in,
   input  wire logic       load_in,
   input  wire logic [7:0] tx_in,
   output logic            line_out,
   output logic [7:0]      rx_out
);
   localparam int OD_THR  = (OD_LOW1_CYC + OD_LOW0_CYC) / 2;
   localparam int STD_THR = (STD_LOW1_CYC + STD_LOW0_CYC) / 2;
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W-1:0] hold_cnt;
   logic [2:0]       idx;
   logic [7:0]       tx;
   logic             oe_q;

   // pull-up wins only when nobody drives low
   assign line_out = !(oe_in || hold_cnt != '0);

   // decode master slots by low time; answer read slots with tx bits
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         low_cnt  <= '0;
         hold_cnt <= '0;
         idx      <= 3'h0;
         tx       <= 8'hff;
         oe_q     <= 1'b0;
         rx_out   <= 8'h00;
      end else begin
         oe_q <= oe_in;
         if (hold_cnt != '0) hold_cnt <= hold_cnt - 1'b1;
         if (load_in) begin
            tx  <= tx_in;
            idx <= 3'h0;
         end else if (oe_in && !oe_q) begin
            low_cnt <= CNT_W'(1);
            idx     <= idx + 3'h1;
            // hold past the sample point so a zero is seen
            if (!tx[idx])
               hold_cnt <= od_in ? CNT_W'(OD_SAMPLE_CYC + 10)
                                 : CNT_W'(STD_SAMPLE_CYC + 25);
         end else if (oe_in) begin
            low_cnt <= low_cnt + 1'b1;
         end
         // first bit on the line lands in bit 0 after eight slots
         if (!oe_in && oe_q)
            rx_out <= {int'(low_cnt) < (od_in ? OD_THR : STD_THR),
                       rx_out[7:1]};
      end
   end
endmodule // swb_slave_model

// file: bench/tb.sv
// self-checking bench of the byte engine against one slave model
// assumes default slot timings, so standard-speed bytes run long

`timescale 1ns/1ps

// ********************************************************************
// bench top
// ********************************************************************
module tb;
   import swb_pkg::*;
   logic       sys_clk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic       cmd_valid  = 1'b0;
   logic       data_valid = 1'b0;
   logic       od = 1'b0, strong_pullup_enable = 1'b0, active_pullup_enable = 1'b0, load = 1'b0;
   logic [7:0] cmd_code = 8'h00, data = 8'h00, tx = 8'hff;
   logic       cmd_ack, data_ack, ptr, busy, rdv, line_o, oe, sp, ap, line;
   logic [7:0] rd_data, rx;
   int         bad_count = 0;
   int         comparisons = 0;

   initial forever #20 sys_clk_in = ~sys_clk_in;

   swb_byte_engine swb_byte_engine_inst (.sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid),
      .cmd_code_in(cmd_code), .data_valid_in(data_valid), .data_in(data),
      .overdrive_speed_select_in(od), .strong_pullup_enable_in(strong_pullup_enable),
      .active_pullup_enable_in(active_pullup_enable), .line_in(line), .cmd_ack_out(cmd_ack),
      .data_ack_out(data_ack), .read_ptr_status_out(ptr),
      .line_busy_flag_out(busy), .read_data_out(rd_data),
      .read_data_valid_out(rdv), .line_out(line_o), .line_oe_out(oe),
      .strong_pullup_out(sp), .active_pullup_out(ap));

   swb_slave_model swb_slave_model_inst (.sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in), .oe_in(oe), .od_in(od), .load_in(load),
      .tx_in(tx), .line_out(line), .rx_out(rx));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("counts: comparisons=%0d mismatches=%0d",
               comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic load_tx(input logic [7:0] v);
      @(posedge sys_clk_in);
      load <= 1'b1;
      tx   <= v;
      @(posedge sys_clk_in);
      load <= 1'b0;
   endtask

   // code strobe, then optional parameter strobe; cfg is {od, spu, apu}
   task automatic send(input logic [7:0] code, input logic [7:0] d,
                       input bit has_d, input logic ok, input logic [2:0] cfg);
      @(posedge sys_clk_in);
      cmd_valid <= 1'b1;
      cmd_code  <= code;
      {od, strong_pullup_enable, active_pullup_enable} <= cfg;
      @(negedge sys_clk_in);
      check(cmd_ack, ok);
      @(posedge sys_clk_in);
      cmd_valid <= 1'b0;
      @(negedge sys_clk_in);
      check(ptr, ok);
      if (has_d) begin
         @(posedge sys_clk_in);
         data_valid <= 1'b1;
         data       <= d;
         @(negedge sys_clk_in);
         check(data_ack, ok);
         @(posedge sys_clk_in);
         data_valid <= 1'b0;
         @(negedge sys_clk_in);
      end
      if (ok) check(busy, 1'b1);
   endtask

   // exp is {read valid seen, strong pullup seen, active pullup seen}
   task automatic wait_done(input int nslots, input bit timed,
                            input logic [2:0] exp);
      int         n;
      int         first;
      int         slot;
      logic [2:0] seen;
      n = 0;
      first = 0;
      seen = 3'b000;
      slot = od ? OD_SLOT_CYC : STD_SLOT_CYC;
      // the host waits for the line to go quiet before the next command
      while (busy !== 1'b0 && n < 20000) begin
         @(negedge sys_clk_in);
         n++;
         if (oe === 1'b1 && first == 0) first = n;
         seen |= {rdv === 1'b1, sp === 1'b1, ap === 1'b1};
      end
      if (timed) begin
         check(first > 0 && first <= START_MAX_CYC, 1);
         check(n >= nslots * slot && n <= nslots * slot + 6, 1);
      end
      check(busy, 1'b0);
      check(line_o, 1'b0);
      check(seen, exp);
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk_in);
      bad_count++;
      complete_run();
   end

   initial begin
      repeat (5) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      // standard write then standard read
      send(CMD_WRITE_BYTE, 8'h2c, 1, 1'b1, 3'b011);
      wait_done(8, 1, 3'b011);
      check(rx, 8'h2c);
      $display("test 1 std write done");
      load_tx(8'h3a);
      send(CMD_READ_BYTE, 8'h00, 0, 1'b1, 3'b010);
      wait_done(8, 1, 3'b100);
      check(rd_data, 8'h3a);
      check(rx, 8'hff);
      $display("test 2 std read done");
      // overdrive write and read
      send(CMD_WRITE_BYTE, 8'h81, 1, 1'b1, 3'b101);
      wait_done(8, 1, 3'b001);
      check(rx, 8'h81);
      load_tx(8'hc5);
      send(CMD_READ_BYTE, 8'h00, 0, 1'b1, 3'b111);
      wait_done(8, 1, 3'b101);
      check(rd_data, 8'hc5);
      $display("test 3 od bytes done");
      // commands while busy are refused and leave no trace
      load_tx(8'h00);
      send(CMD_READ_BYTE, 8'h00, 0, 1'b1, 3'b100);
      send(CMD_WRITE_BYTE, 8'h00, 1, 1'b0, 3'b100);
      send(CMD_READ_BYTE, 8'h00, 0, 1'b0, 3'b100);
      wait_done(8, 0, 3'b100);
      check(rd_data, 8'h00);
      check(rx, 8'hff);
      $display("test 4 busy refusal done");
      // single bit: only bit 7 counts; unknown code not taken
      send(CMD_SINGLE_BIT, 8'h7f, 1, 1'b1, 3'b100);
      wait_done(1, 1, 3'b000);
      check(rx[7], 1'b0);
      send(CMD_SINGLE_BIT, 8'h80, 1, 1'b1, 3'b100);
      wait_done(1, 1, 3'b000);
      check(rx[7], 1'b1);
      send(8'h78, 8'h00, 0, 1'b0, 3'b100);
      check(busy, 1'b0);
      $display("test 5 single bit done");
      complete_run();
   end
endmodule // tb
